//--- common/tcs_pkg.sv
// shared constants and types for the timer clock source block
package tcs_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NCHAN  = 3;
	localparam int NEXT   = 3;
	localparam int NPIN   = 4;

	// register byte offsets
	localparam logic [7:0] CSEL_BASE   = 8'h00;
	localparam logic [7:0] CSEL_STRIDE = 8'h40;
	localparam logic [7:0] XSEL_OFF    = 8'hC4;
	localparam logic [7:0] LSTAT_OFF   = 8'hD0;
	localparam logic [7:0] FEAT_OFF    = 8'hF8;
	localparam logic [7:0] VER_OFF     = 8'hFC;

	// field layout
	localparam int CSEL_W          = 3;
	localparam int XSEL_W          = 2;
	localparam int FEAT_WIDTH_LSB  = 0;
	localparam int FEAT_WIDTH_W    = 8;
	localparam int FEAT_UPDN_BIT   = 9 - 1;
	localparam int FEAT_BRIDGE_BIT = 9;
	localparam int VER_NUM_LSB     = 0;
	localparam int VER_NUM_W       = 12;
	localparam int VER_VAR_LSB     = 16;
	localparam int VER_VAR_W       = 4;
	localparam int LSTAT_EXT_LSB   = 0;
	localparam int LSTAT_SLOW_BIT  = 3;
	localparam int LSTAT_PIN_LSB   = 4;

	// reset and constant values
	localparam logic [CSEL_W-1:0]     CSEL_RST = 3'h0;
	localparam logic [2*NEXT-1:0]     XSEL_RST = 6'h00;
	localparam logic [DATA_W-1:0]     FEAT_RST = 32'h00000310;
	localparam logic [DATA_W-1:0]     RD_IDLE  = 32'h00000000;

	// clock figures: slow oscillator in kHz, core clock in MHz
	localparam int SLOW_KHZ = 32;
	localparam int CORE_MHZ = 100;
	localparam int SLOW_PERIOD_CYC = (CORE_MHZ * 1000) / SLOW_KHZ;

	// prescaler divisions for internal choices 2..5
	localparam int NDIV = 4;
	localparam int DIV_LOG2 [NDIV] = '{1, 3, 5, 7};

	typedef enum logic [CSEL_W-1:0] {
		TCS_SRC_SLOW  = 3'h0,
		TCS_SRC_DIV2  = 3'h1,
		TCS_SRC_DIV8  = 3'h2,
		TCS_SRC_DIV32 = 3'h3,
		TCS_SRC_DIV128 = 3'h4,
		TCS_SRC_EXT0  = 3'h5,
		TCS_SRC_EXT1  = 3'h6,
		TCS_SRC_EXT2  = 3'h7
	} tcs_src_e;

	typedef enum logic [XSEL_W-1:0] {
		TCS_XS_PIN   = 2'h0,
		TCS_XS_NONE  = 2'h1,
		TCS_XS_LINEA = 2'h2,
		TCS_XS_LINEB = 2'h3
	} tcs_xsel_e;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} tcs_bus_req_s;

	// bit 0 slow oscillator, bits 3:1 external clock pins 0..2
	typedef struct packed {
		logic [NEXT-1:0] ext_pin;
		logic            slow_clk;
	} tcs_pins_s;

endpackage : tcs_pkg

//--- core/tcs_prescaler.sv
// free-running divider making the bus-clock tick choices
`timescale 1ns/10ps
module tcs_prescaler #(
	parameter int CNT_W = 7
) (
	input  wire logic                    core_clk,
	input  wire logic                    nrst,
	output logic [tcs_pkg::NDIV-1:0]     div_tick
);

	typedef struct packed {
		logic [CNT_W-1:0]         cnt;
		logic [tcs_pkg::NDIV-1:0] tick;
	} tcs_pre_s;

	tcs_pre_s state;
	tcs_pre_s next_state;

	if (CNT_W < tcs_pkg::DIV_LOG2[tcs_pkg::NDIV-1])
		$error("prescaler counter too narrow for largest division");

	function automatic logic low_ones(input logic [CNT_W-1:0] v,
		input int n);
		logic r;
		r = 1'b1;
		for (int i = 0; i < n; i++)
		begin
			r = r & v[i];
		end
		return r;
	endfunction : low_ones

	always_comb
	begin
		next_state     = state;
		next_state.cnt = state.cnt + CNT_W'(1);
		// tick once every 2**k cycles, a single cycle wide
		for (int d = 0; d < tcs_pkg::NDIV; d++)
		begin
			next_state.tick[d] = low_ones(state.cnt, tcs_pkg::DIV_LOG2[d]);
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			state <= '0;
		else
			state <= next_state;
	end

	assign div_tick = state.tick;

endmodule : tcs_prescaler

//--- core/tcs_clock_source.sv
// per-channel counter clock selection and identification registers
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps

// Function
// - each channel selects its clock independently
// - choice one is slow oscillator clock
// - choices two, three: bus clock /2, /8
// - choices four, five: bus clock /32, /128
// - channels may count external lines 0..2
// - line 0 select: pin, none, A1, A2
// - read-only features register, counter width field
// - features bit 8 flags up/down counting
// - features bit 9 flags bridge kind
// - features constant from reset onward
// - read-only version register, number and variant
module tcs_clock_source #(
	parameter logic [tcs_pkg::VER_NUM_W-1:0] VERSION_NUM = 12'h100,
	parameter logic [tcs_pkg::VER_VAR_W-1:0] VARIANT_NUM = 4'h0
) (
	input  wire logic                          core_clk,
	input  wire logic                          nrst,
	input  wire tcs_pkg::tcs_bus_req_s         bus_req,
	output logic [tcs_pkg::DATA_W-1:0]         rdata,
	input  wire tcs_pkg::tcs_pins_s            pins,
	input  wire logic [tcs_pkg::NCHAN-1:0]     chan_line_a,
	output logic [tcs_pkg::NEXT-1:0]           ext_line,
	output logic [tcs_pkg::NCHAN-1:0]          count_tick
);

	// VERSION_NUM and VARIANT_NUM defaults are arbitrary
	localparam int NP = tcs_pkg::NPIN;
	localparam int NC = tcs_pkg::NCHAN;
	localparam int NX = tcs_pkg::NEXT;
	// capability fields: 16-bit counter, up/down present, bridge flag set
	localparam logic [tcs_pkg::FEAT_WIDTH_W-1:0] CTR_BITS     = 8'h10;
	localparam logic                             UPDN_PRESENT = 1'b1;
	localparam logic                             BRIDGE_FLAG  = 1'b1;

	typedef enum logic [5:0] {
		TCS_REG_CHAN  = 6'h01,
		TCS_REG_XSEL  = 6'h02,
		TCS_REG_LSTAT = 6'h04,
		TCS_REG_FEAT  = 6'h08,
		TCS_REG_VER   = 6'h10,
		TCS_REG_NONE  = 6'h20
	} tcs_reg_e;

	typedef struct packed {
		logic [NP-1:0]                       sync1;
		logic [NP-1:0]                       sync2;
		logic [NP-1:0]                       sync3;
		logic [NP-1:0]                       level;
		logic                                slow_prev;
		logic [NC-1:0][tcs_pkg::CSEL_W-1:0]  csel;
		logic [2*NX-1:0]                     xsel;
		logic [NX-1:0]                       line;
		logic [NX-1:0]                       line_prev;
		logic [NC-1:0]                       tick;
		logic [tcs_pkg::DATA_W-1:0]          rdata;
	} tcs_state_s;

	tcs_state_s                 state;
	tcs_state_s                 next_state;
	logic [tcs_pkg::NDIV-1:0]   div_tick;

	if (VERSION_NUM == '0)
		$error("version number must not be zero");

	tcs_prescaler #(
		.CNT_W (tcs_pkg::DIV_LOG2[tcs_pkg::NDIV-1])
	) u_prescaler (
		.core_clk (core_clk),
		.nrst     (nrst),
		.div_tick (div_tick)
	);

	// which channel select register an address hits; NC on a miss
	function automatic int chan_index(input logic [tcs_pkg::ADDR_W-1:0] a);
		int r;
		r = NC;
		for (int i = 0; i < NC; i++)
		begin
			if (a == tcs_pkg::CSEL_BASE
				+ tcs_pkg::ADDR_W'(i) * tcs_pkg::CSEL_STRIDE)
				r = i;
		end
		return r;
	endfunction : chan_index

	// source of one external line from its 2-bit selection
	function automatic logic ext_pick(input logic [1:0] sel,
		input logic pin, input logic line_x, input logic line_y);
		logic r;
		r = 1'b0;
		case (tcs_pkg::tcs_xsel_e'(sel))
			tcs_pkg::TCS_XS_PIN:   r = pin;
			tcs_pkg::TCS_XS_NONE:  r = 1'b0;
			tcs_pkg::TCS_XS_LINEA: r = line_x;
			tcs_pkg::TCS_XS_LINEB: r = line_y;
			default:               r = 1'b0;
		endcase
		return r;
	endfunction : ext_pick

	function automatic logic rise(input logic now, input logic was);
		return now & ~was;
	endfunction : rise

	function automatic logic [tcs_pkg::DATA_W-1:0] version_word();
		logic [tcs_pkg::DATA_W-1:0] w;
		w = '0;
		w[tcs_pkg::VER_NUM_LSB +: tcs_pkg::VER_NUM_W] = VERSION_NUM;
		w[tcs_pkg::VER_VAR_LSB +: tcs_pkg::VER_VAR_W] = VARIANT_NUM;
		return w;
	endfunction : version_word

	// capability word from its fields, held against the fixed value
	function automatic logic [tcs_pkg::DATA_W-1:0] feat_word();
		logic [tcs_pkg::DATA_W-1:0] w;
		w = '0;
		w[tcs_pkg::FEAT_WIDTH_LSB +: tcs_pkg::FEAT_WIDTH_W] = CTR_BITS;
		w[tcs_pkg::FEAT_UPDN_BIT]   = UPDN_PRESENT;
		w[tcs_pkg::FEAT_BRIDGE_BIT] = BRIDGE_FLAG;
		return w;
	endfunction : feat_word

	function automatic logic [tcs_pkg::DATA_W-1:0] lstat_word(
		input logic [NX-1:0] line, input logic slow,
		input logic [NX-1:0] pin);
		logic [tcs_pkg::DATA_W-1:0] w;
		w = '0;
		w[tcs_pkg::LSTAT_EXT_LSB +: NX] = line;
		w[tcs_pkg::LSTAT_SLOW_BIT]      = slow;
		w[tcs_pkg::LSTAT_PIN_LSB +: NX] = pin;
		return w;
	endfunction : lstat_word

	// one decoder shared by the read and write paths
	function automatic tcs_reg_e reg_decode(
		input logic [tcs_pkg::ADDR_W-1:0] a);
		tcs_reg_e r;
		if (chan_index(a) < NC)
			r = TCS_REG_CHAN;
		else if (a == tcs_pkg::XSEL_OFF)
			r = TCS_REG_XSEL;
		else if (a == tcs_pkg::LSTAT_OFF)
			r = TCS_REG_LSTAT;
		else if (a == tcs_pkg::FEAT_OFF)
			r = TCS_REG_FEAT;
		else if (a == tcs_pkg::VER_OFF)
			r = TCS_REG_VER;
		else
			r = TCS_REG_NONE;
		return r;
	endfunction : reg_decode

	// divisions must stay the bus-clock choices the channels expect
	if ((1 << tcs_pkg::DIV_LOG2[0]) != 2)
		$error("first division must be two");
	if ((1 << tcs_pkg::DIV_LOG2[1]) != 8)
		$error("second division must be eight");
	if ((1 << tcs_pkg::DIV_LOG2[2]) != 32)
		$error("third division must be thirty-two");
	if ((1 << tcs_pkg::DIV_LOG2[3]) != 128)
		$error("fourth division must be one hundred twenty-eight");
	if ((1 << tcs_pkg::CSEL_W) < 5 + NX)
		$error("select field too narrow for all sources");
	if (NP != NX + 1)
		$error("pin bundle must carry slow clock and external pins");
	if (2 * NX > tcs_pkg::DATA_W)
		$error("external select fields exceed data width");
	if (tcs_pkg::CSEL_BASE + (NC - 1) * tcs_pkg::CSEL_STRIDE
		>= tcs_pkg::XSEL_OFF)
		$error("channel selects overlap block registers");
	if (tcs_pkg::LSTAT_SLOW_BIT < tcs_pkg::LSTAT_EXT_LSB + NX)
		$error("slow level bit overlaps line bits");
	if (tcs_pkg::LSTAT_PIN_LSB + NX > tcs_pkg::DATA_W)
		$error("pin level field beyond data width");
	if (tcs_pkg::FEAT_UPDN_BIT < tcs_pkg::FEAT_WIDTH_LSB
		+ tcs_pkg::FEAT_WIDTH_W)
		$error("up/down flag overlaps width field");
	if (feat_word() != tcs_pkg::FEAT_RST)
		$error("capability fields disagree with fixed word");
	if (tcs_pkg::VER_NUM_LSB + tcs_pkg::VER_NUM_W > tcs_pkg::VER_VAR_LSB)
		$error("version number overlaps variant field");
	if (tcs_pkg::VER_VAR_LSB + tcs_pkg::VER_VAR_W > tcs_pkg::DATA_W)
		$error("variant field beyond data width");

	logic [NX-1:0]          pin_level;
	logic                   slow_rise;
	logic [NX-1:0]          line_rise;
	logic [NX-1:0]          next_line;
	logic [7:0]             src_tick;
	int                     widx;
	int                     ridx;
	tcs_reg_e               rsel;
	logic [tcs_pkg::DATA_W-1:0] rd_word;

	always_comb
	begin
		pin_level = state.level[NP-1:1];
		slow_rise = rise(state.level[0], state.slow_prev);
		for (int k = 0; k < NX; k++)
		begin
			line_rise[k] = rise(state.line[k], state.line_prev[k]);
		end
	end

	// external line selection, same table shape for each line
	always_comb
	begin
		// line 0: pin 0, none, channel 1 A, channel 2 A
		next_line[0] = ext_pick(state.xsel[1:0], pin_level[0],
			chan_line_a[1], chan_line_a[2]);
		next_line[1] = ext_pick(state.xsel[3:2], pin_level[1],
			chan_line_a[0], chan_line_a[2]);
		next_line[2] = ext_pick(state.xsel[5:4], pin_level[2],
			chan_line_a[0], chan_line_a[1]);
	end

	always_comb
	begin
		src_tick[tcs_pkg::TCS_SRC_SLOW]   = slow_rise;
		// bus clock divided by 2 and 8
		src_tick[tcs_pkg::TCS_SRC_DIV2]   = div_tick[0];
		src_tick[tcs_pkg::TCS_SRC_DIV8]   = div_tick[1];
		// bus clock divided by 32 and 128
		src_tick[tcs_pkg::TCS_SRC_DIV32]  = div_tick[2];
		src_tick[tcs_pkg::TCS_SRC_DIV128] = div_tick[3];
		src_tick[tcs_pkg::TCS_SRC_EXT0]   = line_rise[0];
		src_tick[tcs_pkg::TCS_SRC_EXT1]   = line_rise[1];
		src_tick[tcs_pkg::TCS_SRC_EXT2]   = line_rise[2];
	end

	always_comb
	begin
		widx = chan_index(bus_req.addr);
		ridx = widx;
		rsel = reg_decode(bus_req.addr);
		rd_word = tcs_pkg::RD_IDLE;
		if (rsel == TCS_REG_CHAN && ridx < NC)
		begin
			rd_word[tcs_pkg::CSEL_W-1:0] = state.csel[ridx];
		end
		else if (rsel == TCS_REG_XSEL)
		begin
			rd_word[2*NX-1:0] = state.xsel;
		end
		else if (rsel == TCS_REG_LSTAT)
		begin
			rd_word = lstat_word(state.line, state.level[0], pin_level);
		end
		else if (rsel == TCS_REG_FEAT)
		begin
			rd_word = tcs_pkg::FEAT_RST;
		end
		else if (rsel == TCS_REG_VER)
		begin
			rd_word = version_word();
		end
		else
		begin
			rd_word = tcs_pkg::RD_IDLE;
		end
	end

	always_comb
	begin
		next_state = state;

		// three stages; only agreeing stages 2 and 3 update the level
		next_state.sync1 = pins;
		next_state.sync2 = state.sync1;
		next_state.sync3 = state.sync2;
		for (int p = 0; p < NP; p++)
		begin
			if (state.sync2[p] == state.sync3[p])
				next_state.level[p] = state.sync3[p];
		end
		next_state.slow_prev = state.level[0];

		// external lines registered, edges taken on the copy
		next_state.line      = next_line;
		next_state.line_prev = state.line;

		// each channel looks only at its own select
		for (int c = 0; c < NC; c++)
		begin
			next_state.tick[c] = src_tick[state.csel[c]];
		end

		// features, version and unmapped writes fall through
		if (bus_req.wr)
		begin
			if (rsel == TCS_REG_CHAN && widx < NC)
			begin
				next_state.csel[widx] = bus_req.wdata[tcs_pkg::CSEL_W-1:0];
			end
			else if (rsel == TCS_REG_XSEL)
			begin
				next_state.xsel = bus_req.wdata[2*NX-1:0];
			end
		end

		// read data stands only in the cycle after the strobe
		if (bus_req.rd)
			next_state.rdata = rd_word;
		else
			next_state.rdata = tcs_pkg::RD_IDLE;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state      <= '0;
			state.csel <= {NC{tcs_pkg::CSEL_RST}};
			state.xsel <= tcs_pkg::XSEL_RST;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign rdata      = state.rdata;
	assign ext_line   = state.line;
	assign count_tick = state.tick;

endmodule : tcs_clock_source

//--- bench/tcs_clock_source_props.sv
// assertions for the timer clock source block
`timescale 1ns/10ps
module tcs_clock_source_props #(
	parameter logic [tcs_pkg::VER_NUM_W-1:0] VERSION_NUM = 12'h100,
	parameter logic [tcs_pkg::VER_VAR_W-1:0] VARIANT_NUM = 4'h0
) (
	input wire logic                        core_clk,
	input wire logic                        nrst,
	input wire tcs_pkg::tcs_bus_req_s       bus_req,
	input wire logic [tcs_pkg::DATA_W-1:0]  rdata,
	input wire tcs_pkg::tcs_pins_s          pins,
	input wire logic [tcs_pkg::NCHAN-1:0]   chan_line_a,
	input wire logic [tcs_pkg::NEXT-1:0]    ext_line,
	input wire logic [tcs_pkg::NCHAN-1:0]   count_tick
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic [2:0] sel0;
	// shadow of channel 0 select, seen from the bus only
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
			sel0 <= 3'h0;
		else if (bus_req.wr && bus_req.addr == 8'h00)
			sel0 <= bus_req.wdata[2:0];
	logic [1:0] xs0;
	// shadow of external line 0 select, seen from the bus only
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
			xs0 <= 2'h0;
		else if (bus_req.wr && bus_req.addr == 8'hC4)
			xs0 <= bus_req.wdata[1:0];
	line_none_a: assert property (
		xs0 == 2'h1 |=> !ext_line[0]) else $error("line 0 not idle");
	line_chan_a: assert property (
		xs0 == 2'h2 |=> ext_line[0] == $past(chan_line_a[1]))
		else $error("line 0 not channel 1 line");
	rd_idle_a: assert property (
		!bus_req.rd |=> rdata == 32'h0) else $error("rdata not idle");
	feat_value_a: assert property (
		bus_req.rd && bus_req.addr == 8'hF8 |=> rdata == 32'h00000310)
		else $error("features value wrong");
	feat_field_a: assert property (
		bus_req.rd && bus_req.addr == 8'hF8
		|=> rdata[7:0] == 8'h10 && rdata[9:8] == 2'h3)
		else $error("features fields wrong");
	ver_value_a: assert property (
		bus_req.rd && bus_req.addr == 8'hFC
		|=> rdata == {12'h0, VARIANT_NUM, 4'h0, VERSION_NUM})
		else $error("version value wrong");
	csel_width_a: assert property (
		bus_req.rd && bus_req.addr inside {8'h00, 8'h40, 8'h80}
		|=> rdata[31:3] == 29'h0) else $error("select width wrong");
	xsel_width_a: assert property (
		bus_req.rd && bus_req.addr == 8'hC4
		|=> rdata[31:6] == 26'h0) else $error("ext select width wrong");
	tick_pulse_a: assert property (
		count_tick[0] && sel0 < 3'h5 && $past(sel0) == sel0
		&& $past(sel0, 2) == sel0 |=> !count_tick[0])
		else $error("tick longer than one cycle");
	div2_tick_a: assert property (
		(sel0 == 3'h1) [*4] ##0 count_tick[0]
		|=> !count_tick[0] ##1 (count_tick[0] || sel0 != 3'h1))
		else $error("half rate tick missing");
	c_feat: cover property (bus_req.rd && bus_req.addr == 8'hF8);
	c_div2: cover property (sel0 == 3'h1 && count_tick[0]);
	c_ext: cover property (sel0 == 3'h5 && count_tick[0]);
endmodule : tcs_clock_source_props
bind tcs_clock_source tcs_clock_source_props #(
	.VERSION_NUM(VERSION_NUM), .VARIANT_NUM(VARIANT_NUM)) u_props (
	.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req), .rdata(rdata),
	.pins(pins), .chan_line_a(chan_line_a), .ext_line(ext_line),
	.count_tick(count_tick));

//--- bench/tcs_clock_source_tb_top.sv
// self-checking bench for the timer clock source block
`timescale 1ns/10ps
module tcs_clock_source_tb_top;
	localparam logic [11:0] VNUM = 12'h5A3; // arbitrary value
	localparam logic [3:0]  VVAR = 4'h6;    // arbitrary value
	logic                   core_clk = 1'b0;
	logic                   nrst = 1'b0;
	tcs_pkg::tcs_bus_req_s  bus_req = '0;
	tcs_pkg::tcs_pins_s     pins;
	logic [31:0]            rdata;
	logic [2:0]             chan_line_a;
	logic [2:0]             ext_line;
	logic [2:0]             count_tick;
	logic [9:0]             cyc = 10'h000;
	logic [31:0]            exp_q[$];
	logic                   pend = 1'b0;
	int fail_count = 0;
	int total_checks = 0;
	int seed = 84;
	int n[3];
	// window of 1280 cycles divided by each source period
	int esel[8] = '{1280/256, 1280/2, 1280/8, 1280/32, 1280/128,
		1280/16, 1280/32, 1280/64};
	int exs[4] = '{1280/16, 0, 1280/64, 1280/128};
	tcs_clock_source #(.VERSION_NUM(VNUM), .VARIANT_NUM(VVAR)) u_dut (
		.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req),
		.rdata(rdata), .pins(pins), .chan_line_a(chan_line_a),
		.ext_line(ext_line), .count_tick(count_tick));
	initial forever #5 core_clk = ~core_clk;
	// periodic pins: distinct periods expose mux swaps
	always @(posedge core_clk) cyc <= cyc + 10'h001;
	assign pins.slow_clk = cyc[7];
	assign pins.ext_pin = cyc[5:3];
	assign chan_line_a = cyc[6:4];
	task automatic check(input string nm, input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	task automatic op(input logic w, r, input logic [7:0] a,
		input logic [31:0] d);
		bus_req <= '{w, r, a, d};
		if (r)
			exp_q.push_back(d);
		@(posedge core_clk);
	endtask : op
	task automatic measure(input int e0, e1, e2);
		n = '{0, 0, 0};
		repeat (16) @(posedge core_clk);
		repeat (1280)
		begin
			@(negedge core_clk);
			foreach (n[k])
				n[k] += count_tick[k];
		end
		check("tick0", n[0], e0);
		check("tick1", n[1], e1);
		check("tick2", n[2], e2);
		@(posedge core_clk);
	endtask : measure
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	always @(posedge core_clk)
	begin
		if (pend)
			check("rdata", rdata, exp_q.pop_front());
		pend = bus_req.rd;
	end
	initial
	begin
		#500000;
		fail_count++;
		conclude();
	end
	initial
	begin
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		op(1, 0, 8'hF8, $random(seed));
		op(0, 1, 8'hF8, 32'h00000310);
		op(1, 0, 8'hFC, $random(seed));
		op(0, 1, 8'hFC, {12'h0, VVAR, 4'h0, VNUM});
		op(0, 1, 8'h10, 32'h0);
		for (int s = 0; s < 8; s++)
		begin
			op(1, 0, 8'h00, ($random(seed) & 32'hFFFFFFF8) | s);
			op(0, 1, 8'h00, s);
			op(0, 0, 8'h00, 0);
			measure(esel[s], 5, 5);
		end
		op(1, 0, 8'h00, 32'h5);
		for (int x = 0; x < 4; x++)
		begin
			op(1, 0, 8'hC4, x);
			op(0, 1, 8'hC4, x);
			op(0, 0, 8'h00, 0);
			measure(exs[x], 5, 5);
		end
		// three channels on three sources at once
		op(1, 0, 8'h00, 32'h1);
		op(1, 0, 8'h40, 32'h2);
		op(1, 0, 8'h80, 32'h3);
		op(0, 0, 8'h00, 0);
		measure(1280/2, 1280/8, 1280/32);
		op(0, 1, 8'hF8, 32'h00000310);
		op(0, 0, 8'h00, 0);
		conclude();
	end
endmodule : tcs_clock_source_tb_top
